// *** rtl/msm_menu.sv ***
`default_nettype none
// What this block does
// - Holding mode key one second enters settings, reference screen shown first.
// - Holding mode key two seconds leaves settings through calibration to main.
// - Reference screen: decrement resets processor, increment toggles F/C.
// - User alarm setpoint 1.0 to 5.0 in 0.1 steps, down/up keys.
// - Alarm power floor cycles 0, 0.1, 1, 10 W on decrement; default 0.
// - Power floor suppresses only the alarm, never blanks SWR display.
// - Increment toggles forward or net power display; default net.
// - Decrement cycles low, mid, high range on scale screen.
// - Increment steps selected range maximum through its list; defaults 15/100/1500.
// - Bargraph full scale is maximum plus ten percent.
// - Maxima scaled 1.67 for 5 kW coupler, 3.33 for 10 kW.
// - Average/tune span is chosen dB below max, default 12; peak fixed 13.
// - Power averaging 2 to 24 default 8; SWR averaging 0 to 5 default 2.
// - Decrement steps power averaging, increment SWR averaging, both wrap.
// - Power averaging only in average mode; SWR averaging in all modes.
// - Peak hold 0.25 to 5 seconds via down/up keys; default 2 seconds.
// - Decay fast, medium or slow, default medium; slow about three seconds.
// - Attack always fast, responds to one element at 100 wpm.
// - Coupler cycles six entries 3k,5k,250,5k,10k,1k W; first is default.
// - Idle SWR style dash, 1.00, blank, hold; hold cleared on transmit.
module msm_menu
    import msm_pkg::*;
#(
    parameter int unsigned ENTER_CYC  = ENTER_HOLD_CYC,
    parameter int unsigned EXIT_CYC   = EXIT_HOLD_CYC,
    parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
) (
    input  wire logic                      CLK,
    input  wire logic                      RST,
    input  wire logic                      MODE_KEY,
    input  wire logic                      DECREMENT_KEY,
    input  wire logic                      INCREMENT_KEY,
    input  wire logic                      RESTORE_VALID,
    input  wire msm_pkg::msm_settings_type RESTORE_DATA,
    input  wire logic                      PEAK_MODE,
    input  wire logic                      AVG_MODE,
    input  wire logic                      TRANSMITTING,
    input  wire logic                      SWR_ALARM_RAW,
    input  wire logic                      BELOW_FLOOR,
    output msm_pkg::msm_settings_type      SETTINGS,
    output logic                           SETUP_ACTIVE,
    output logic                           CAL_ACTIVE,
    output msm_pkg::msm_screen_type        SCREEN,
    output logic                           CPU_RESET,
    output logic [15:0]                    SCALE_MAX_W,
    output logic [15:0]                    SCALE_FULL_W,
    output logic [4:0]                     SPAN_DB,
    output logic [4:0]                     POWER_AVG_USED,
    output logic                           SWR_ALARM,
    output logic                           CLEAR_HELD_SWR
);
    import msm_pkg::*;

    // ------------------------------------------------------------
    // Key conditioning and edges
    // ------------------------------------------------------------
    logic mode_lvl;
    logic dn_lvl;
    logic up_lvl;
    logic mode_d_r;
    logic dn_d_r;
    logic up_d_r;
    logic tx_s1_r;
    logic tx_s2_r;
    logic tx_d_r;

    msm_key_filter #(.STABLE_CYC(STABLE_CYC)) u_mode (
        .clk   (CLK),
        .rst   (RST),
        .raw   (MODE_KEY),
        .level (mode_lvl)
    );
    msm_key_filter #(.STABLE_CYC(STABLE_CYC)) u_dn (
        .clk   (CLK),
        .rst   (RST),
        .raw   (DECREMENT_KEY),
        .level (dn_lvl)
    );
    msm_key_filter #(.STABLE_CYC(STABLE_CYC)) u_up (
        .clk   (CLK),
        .rst   (RST),
        .raw   (INCREMENT_KEY),
        .level (up_lvl)
    );

    always_ff @(posedge CLK) begin
        tx_s1_r <= TRANSMITTING;
        tx_s2_r <= tx_s1_r;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            mode_d_r <= 1'b0;
            dn_d_r   <= 1'b0;
            up_d_r   <= 1'b0;
            tx_d_r   <= 1'b0;
        end else begin
            mode_d_r <= mode_lvl;
            dn_d_r   <= dn_lvl;
            up_d_r   <= up_lvl;
            tx_d_r   <= tx_s2_r;
        end
    end

    // Press edges of the filtered down/up keys, release edge of the mode key, transmit start
    wire dn_press   = dn_lvl & ~dn_d_r;
    wire up_press   = up_lvl & ~up_d_r;
    wire mode_rel   = ~mode_lvl & mode_d_r;
    wire tx_start   = tx_s2_r & ~tx_d_r;

    // ------------------------------------------------------------
    // Mode key hold timer
    // ------------------------------------------------------------
    logic [31:0] hold_r;
    logic        long_done_r;
    logic        setup_r;
    logic        cal_r;

    wire hold_enter = mode_lvl & ~setup_r & ~long_done_r & (hold_r >= ENTER_CYC - 1);
    wire hold_cal   = mode_lvl & setup_r & ~cal_r & (hold_r >= ENTER_CYC - 1);
    wire hold_exit  = mode_lvl & setup_r & ~long_done_r & (hold_r >= EXIT_CYC - 1);
    // Release after any long hold never advances
    wire short_adv  = mode_rel & setup_r & ~long_done_r & ~cal_r;

    always_ff @(posedge CLK) begin
        if (RST) begin
            hold_r      <= 32'h0000_0000;
            long_done_r <= 1'b0;
            setup_r     <= 1'b0;
            cal_r       <= 1'b0;
        end else begin
            hold_r <= mode_lvl ? hold_r + 32'h0000_0001 : 32'h0000_0000;
            if (!mode_lvl) begin
                long_done_r <= 1'b0;
                cal_r       <= 1'b0;
            end
            if (hold_enter) begin
                setup_r     <= 1'b1;
                long_done_r <= 1'b1;
            end else if (hold_cal) begin
                cal_r       <= 1'b1;
            end else if (hold_exit) begin
                setup_r     <= 1'b0;
                cal_r       <= 1'b0;
                long_done_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Screen sequencer
    // ------------------------------------------------------------
    msm_screen_type scr_r;
    msm_screen_type scr_nxt;

    always_comb begin
        case (scr_r)
            SCR_REF:     scr_nxt = SCR_ALARM;
            SCR_ALARM:   scr_nxt = SCR_FLOOR;
            SCR_FLOOR:   scr_nxt = SCR_RANGE;
            SCR_RANGE:   scr_nxt = SCR_SCALE;
            SCR_SCALE:   scr_nxt = SCR_SPAN;
            SCR_SPAN:    scr_nxt = SCR_AVG;
            SCR_AVG:     scr_nxt = SCR_HOLD;
            SCR_HOLD:    scr_nxt = SCR_DECAY;
            SCR_DECAY:   scr_nxt = SCR_COUPLER;
            default:     scr_nxt = SCR_REF;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST || hold_enter) begin
            scr_r <= SCR_REF;
        end else if (short_adv) begin
            scr_r <= scr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Settings store
    // ------------------------------------------------------------
    msm_settings_type s_r;
    msm_settings_type s_nxt;
    logic [3:0]       sel_idx;
    logic [3:0]       sel_last;

    wire editing = setup_r & ~cal_r & ~mode_lvl;
    wire ed_dn   = editing & dn_press;
    wire ed_up   = editing & up_press;
    // Both keys in one cycle on the coupler screen step idle style only
    wire both_ed = ed_dn & ed_up;

    assign sel_idx  = (s_r.range_sel == 2'd0) ? s_r.low_idx :
                      (s_r.range_sel == 2'd1) ? s_r.mid_idx : s_r.high_idx;
    assign sel_last = (s_r.range_sel == 2'd0) ? LOW_LAST :
                      (s_r.range_sel == 2'd1) ? MID_LAST : HIGH_LAST;
    wire [3:0] sel_step = (sel_idx == sel_last) ? 4'h0 : sel_idx + 4'h1;

    always_comb begin
        s_nxt = s_r;
        case (scr_r)
            SCR_REF: begin
                if (ed_up) s_nxt.temp_celsius = ~s_r.temp_celsius;
            end
            SCR_ALARM: begin
                if (ed_dn && s_r.alarm_tenths > ALARM_MIN)
                    s_nxt.alarm_tenths = s_r.alarm_tenths - 6'd1;
                else if (ed_up && s_r.alarm_tenths < ALARM_MAX)
                    s_nxt.alarm_tenths = s_r.alarm_tenths + 6'd1;
            end
            SCR_FLOOR: begin
                if (ed_dn) s_nxt.alarm_power_floor = s_r.alarm_power_floor + 2'd1;
                if (ed_up) s_nxt.power_net = ~s_r.power_net;
            end
            SCR_RANGE, SCR_SCALE: begin
                if (ed_dn)
                    s_nxt.range_sel = (s_r.range_sel == RANGE_LAST) ? 2'd0
                                    : s_r.range_sel + 2'd1;
                else if (ed_up) begin
                    case (s_r.range_sel)
                        2'd0:    s_nxt.low_idx  = sel_step;
                        2'd1:    s_nxt.mid_idx  = sel_step;
                        default: s_nxt.high_idx = sel_step;
                    endcase
                end
            end
            SCR_SPAN: begin
                if (ed_dn && s_r.span_db > SPAN_MIN_DB)
                    s_nxt.span_db = s_r.span_db - 5'd1;
                else if (ed_up && s_r.span_db < SPAN_MAX_DB)
                    s_nxt.span_db = s_r.span_db + 5'd1;
            end
            SCR_AVG: begin
                if (ed_dn)
                    s_nxt.power_avg = (s_r.power_avg >= PAVG_MAX) ? PAVG_MIN
                                    : s_r.power_avg + 5'd1;
                if (ed_up)
                    s_nxt.swr_avg = (s_r.swr_avg >= SAVG_MAX) ? 3'd0
                                  : s_r.swr_avg + 3'd1;
            end
            SCR_HOLD: begin
                if (ed_dn && s_r.hold_qsec > HOLD_MIN)
                    s_nxt.hold_qsec = s_r.hold_qsec - 5'd1;
                else if (ed_up && s_r.hold_qsec < HOLD_MAX)
                    s_nxt.hold_qsec = s_r.hold_qsec + 5'd1;
            end
            SCR_DECAY: begin
                if (ed_dn && s_r.decay != 2'd0)
                    s_nxt.decay = s_r.decay - 2'd1;
                else if (ed_up && s_r.decay != DECAY_LAST)
                    s_nxt.decay = s_r.decay + 2'd1;
            end
            default: begin
                if (ed_dn && !both_ed)
                    s_nxt.coupler = (s_r.coupler == 3'd0) ? COUPLER_LAST
                                  : s_r.coupler - 3'd1;
                else if (ed_up && !both_ed)
                    s_nxt.coupler = (s_r.coupler == COUPLER_LAST) ? 3'd0
                                  : s_r.coupler + 3'd1;
            end
        endcase
        // Idle style steps on a both-key press on the coupler screen
        if (scr_r == SCR_COUPLER && both_ed)
            s_nxt.idle_style = s_r.idle_style + 2'd1;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s_r <= '{alarm_tenths: ALARM_DEF, alarm_power_floor: FLOOR_DEF,
                     power_net: PWR_NET_DEF, range_sel: 2'd0, low_idx: LOW_DEF,
                     mid_idx: MID_DEF, high_idx: HIGH_DEF, span_db: SPAN_DEF_DB,
                     power_avg: PAVG_DEF, swr_avg: SAVG_DEF, hold_qsec: HOLD_DEF,
                     decay: DECAY_DEF, coupler: COUPLER_DEF, idle_style: IDLE_DEF,
                     temp_celsius: 1'b0};
        end else if (RESTORE_VALID && !setup_r) begin
            s_r <= RESTORE_DATA;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Scale tables
    // ------------------------------------------------------------
    // Watts per list index for each range
    function automatic logic [15:0] base_max(input logic [1:0] rng, input logic [3:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        case (rng)
            2'd0:    v = 16'(5 * (idx + 1));
            2'd1:    v = 16'(50 + 25 * idx);
            default: v = (idx == HIGH_LAST) ? 16'd3000 : 16'(500 + 250 * idx);
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Selected maximum and coupler scaling
    // ------------------------------------------------------------
    wire [15:0] max_base = base_max(s_r.range_sel, sel_idx);
    wire        cpl_5k   = (s_r.coupler == 3'd1) || (s_r.coupler == 3'd3);
    wire        cpl_10k  = (s_r.coupler == 3'd4);
    wire [31:0] max_scl  = cpl_10k ? (32'(max_base) * 32'd333) / 32'd100 :
                           cpl_5k  ? (32'(max_base) * 32'd167) / 32'd100 :
                                     32'(max_base);
    wire [31:0] full_scl = max_scl + max_scl / 32'd10;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            SETTINGS       <= '0;
            SETUP_ACTIVE   <= 1'b0;
            CAL_ACTIVE     <= 1'b0;
            SCREEN         <= SCR_REF;
            CPU_RESET      <= 1'b0;
            SCALE_MAX_W    <= 16'h0000;
            SCALE_FULL_W   <= 16'h0000;
            SPAN_DB        <= 5'h00;
            POWER_AVG_USED <= 5'h00;
            SWR_ALARM      <= 1'b0;
            CLEAR_HELD_SWR <= 1'b0;
        end else begin
            SETTINGS       <= s_r;
            SETUP_ACTIVE   <= setup_r;
            CAL_ACTIVE     <= cal_r;
            SCREEN         <= scr_r;
            CPU_RESET      <= ed_dn && (scr_r == SCR_REF);
            SCALE_MAX_W    <= max_scl[15:0];
            SCALE_FULL_W   <= full_scl[15:0];
            SPAN_DB        <= PEAK_MODE ? PEAK_SPAN_DB : s_r.span_db;
            POWER_AVG_USED <= AVG_MODE ? s_r.power_avg : 5'h01;
            SWR_ALARM      <= SWR_ALARM_RAW & ~BELOW_FLOOR;
            CLEAR_HELD_SWR <= tx_start && (s_r.idle_style == IDLE_HOLD);
        end
    end
endmodule
`default_nettype wire

// *** shared/msm_pkg.sv ***
`default_nettype none
package msm_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned ENTER_HOLD_MS   = 1000;
    localparam int unsigned EXIT_HOLD_MS    = 2000;
    localparam int unsigned ENTER_HOLD_CYC  = CLK_HZ / 1000 * ENTER_HOLD_MS;
    localparam int unsigned EXIT_HOLD_CYC   = CLK_HZ / 1000 * EXIT_HOLD_MS;
    localparam int unsigned DEBOUNCE_MS     = 10;
    localparam int unsigned DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;

    // ------------------------------------------------------------
    // Setting limits and defaults (units noted per field)
    // ------------------------------------------------------------
    localparam logic [5:0] ALARM_MIN        = 6'd10;  // Tenths
    localparam logic [5:0] ALARM_MAX        = 6'd50;
    localparam logic [5:0] ALARM_DEF        = 6'd20;
    localparam logic [1:0] FLOOR_DEF        = 2'd0;   // 0, 0.1, 1.0, 10.0 W
    localparam logic [1:0] FLOOR_LAST       = 2'd3;
    localparam logic       PWR_NET_DEF      = 1'b1;
    localparam logic [1:0] RANGE_LAST       = 2'd2;
    localparam logic [3:0] LOW_LAST         = 4'd4;   // Index into max lists
    localparam logic [3:0] MID_LAST         = 4'd8;
    localparam logic [3:0] HIGH_LAST        = 4'd9;
    localparam logic [3:0] LOW_DEF          = 4'd2;
    localparam logic [3:0] MID_DEF          = 4'd2;
    localparam logic [3:0] HIGH_DEF         = 4'd4;
    localparam logic [4:0] SPAN_MIN_DB      = 5'd6;
    localparam logic [4:0] SPAN_MAX_DB      = 5'd24;
    localparam logic [4:0] SPAN_DEF_DB      = 5'd12;
    localparam logic [4:0] PEAK_SPAN_DB     = 5'd13;
    localparam logic [4:0] PAVG_MIN         = 5'd2;
    localparam logic [4:0] PAVG_MAX         = 5'd24;
    localparam logic [4:0] PAVG_DEF         = 5'd8;
    localparam logic [2:0] SAVG_MAX         = 3'd5;
    localparam logic [2:0] SAVG_DEF         = 3'd2;
    localparam logic [4:0] HOLD_MIN         = 5'd1;   // Quarter seconds
    localparam logic [4:0] HOLD_MAX         = 5'd20;
    localparam logic [4:0] HOLD_DEF         = 5'd8;
    localparam logic [1:0] DECAY_LAST       = 2'd2;   // Fast, med, slow
    localparam logic [1:0] DECAY_DEF        = 2'd1;
    localparam logic [2:0] COUPLER_LAST     = 3'd5;
    localparam logic [2:0] COUPLER_DEF      = 3'd0;
    localparam logic [1:0] IDLE_LAST        = 2'd3;   // Dash, 1.00, blank, hold
    localparam logic [1:0] IDLE_DEF         = 2'd0;
    localparam logic [1:0] IDLE_HOLD        = 2'd3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [9:0] {
        SCR_REF     = 10'b00_0000_0001,
        SCR_ALARM   = 10'b00_0000_0010,
        SCR_FLOOR   = 10'b00_0000_0100,
        SCR_RANGE   = 10'b00_0000_1000,
        SCR_SCALE   = 10'b00_0001_0000,
        SCR_SPAN    = 10'b00_0010_0000,
        SCR_AVG     = 10'b00_0100_0000,
        SCR_HOLD    = 10'b00_1000_0000,
        SCR_DECAY   = 10'b01_0000_0000,
        SCR_COUPLER = 10'b10_0000_0000
    } msm_screen_type;

    typedef struct packed {
        logic [5:0]  alarm_tenths;
        logic [1:0]  alarm_power_floor;
        logic        power_net;
        logic [1:0]  range_sel;
        logic [3:0]  low_idx;
        logic [3:0]  mid_idx;
        logic [3:0]  high_idx;
        logic [4:0]  span_db;
        logic [4:0]  power_avg;
        logic [2:0]  swr_avg;
        logic [4:0]  hold_qsec;
        logic [1:0]  decay;
        logic [2:0]  coupler;
        logic [1:0]  idle_style;
        logic        temp_celsius;
    } msm_settings_type;

    localparam int unsigned SET_W = $bits(msm_settings_type);
endpackage
`default_nettype wire

// *** rtl/msm_key_filter.sv ***
`default_nettype none
module msm_key_filter #(
    parameter int unsigned STABLE_CYC = 400_000
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic raw,
    output logic      level
);
    logic       s1_r;
    logic       s2_r;
    logic [31:0] cnt_r;

    always_ff @(posedge clk) begin
        s1_r <= raw;
        s2_r <= s1_r;
    end

    // ------------------------------------------------------------
    // Accept a new level only after it stays put
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 32'h0000_0000;
            level <= 1'b0;
        end else if (s2_r == level) begin
            cnt_r <= 32'h0000_0000;
        end else if (cnt_r >= STABLE_CYC - 1) begin
            cnt_r <= 32'h0000_0000;
            level <= s2_r;
        end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// *** verification/msm_keys.sv ***
`default_nettype none
// ------------------------------------------------------------
// Front-panel keys with contact chatter only on changes that draw a three-clock settle
// ------------------------------------------------------------
module msm_keys (
    input  wire logic       clk,
    input  wire logic [2:0] want,
    output logic            mode_key,
    output logic            dn_key,
    output logic            up_key
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] lvl_r = 3'h0;
    logic [2:0] out_r = 3'h0;
    int         bnc   = 0;
    always @(posedge clk) begin
        if (bnc > 0) begin
            bnc   <= bnc - 1;
            if (bnc == 1) begin
                out_r <= want;
                lvl_r <= want;
            end else begin
                out_r <= out_r ^ (want ^ lvl_r);
            end
        end else if (want != lvl_r) begin
            bnc <= 1 + $urandom % 3;
        end
    end
    assign mode_key = out_r[0];
    assign dn_key   = out_r[1];
    assign up_key   = out_r[2];
endmodule
`default_nettype wire

// *** verification/msm_menu_props.sv ***
`default_nettype none
module msm_menu_props (
    input wire logic                      CLK,
    input wire logic                      RST,
    input wire logic                      PEAK_MODE,
    input wire logic                      AVG_MODE,
    input wire logic                      SWR_ALARM_RAW,
    input wire logic                      BELOW_FLOOR,
    input wire msm_pkg::msm_settings_type SETTINGS,
    input wire logic                      SETUP_ACTIVE,
    input wire logic                      CAL_ACTIVE,
    input wire msm_pkg::msm_screen_type   SCREEN,
    input wire logic                      CPU_RESET,
    input wire logic [15:0]               SCALE_MAX_W,
    input wire logic [15:0]               SCALE_FULL_W,
    input wire logic [4:0]                SPAN_DB,
    input wire logic [4:0]                POWER_AVG_USED,
    input wire logic                      SWR_ALARM,
    input wire logic                      CLEAR_HELD_SWR
);
    import msm_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    alarm_gate_a: assert property (
        !$past(RST) |-> SWR_ALARM == ($past(SWR_ALARM_RAW) && !$past(BELOW_FLOOR)))
        else $error("alarm gate wrong");
    peak_span_a: assert property (
        PEAK_MODE && $past(PEAK_MODE) && !$past(RST) |-> SPAN_DB == PEAK_SPAN_DB)
        else $error("peak span wrong");
    avg_used_a: assert property (
        !AVG_MODE && !$past(AVG_MODE) && !$past(RST) |-> POWER_AVG_USED == 5'h1)
        else $error("averaging outside average mode");
    full_scale_a: assert property (
        $stable(SCALE_MAX_W) && !$past(RST)
        |-> SCALE_FULL_W == SCALE_MAX_W + SCALE_MAX_W / 16'h000a)
        else $error("full scale headroom wrong");
    cpu_pulse_a: assert property (
        CPU_RESET |-> SETUP_ACTIVE && SCREEN == SCR_REF ##1 !CPU_RESET)
        else $error("processor reset pulse wrong");
    cal_setup_a: assert property (CAL_ACTIVE |-> SETUP_ACTIVE)
        else $error("cal outside setup");
    enter_ref_a: assert property ($rose(SETUP_ACTIVE) |-> SCREEN == SCR_REF)
        else $error("setup not on reference");
    screen_hot_a: assert property ($onehot(SCREEN))
        else $error("screen not one-hot");
    clear_hold_a: assert property (
        CLEAR_HELD_SWR |-> SETTINGS.idle_style == IDLE_HOLD ##1 !CLEAR_HELD_SWR)
        else $error("held clear wrong");
    bounds_a: assert property (
        !$past(RST) && !$past(RST, 2)
        |-> SETTINGS.alarm_tenths inside {[ALARM_MIN:ALARM_MAX]}
        && SETTINGS.power_avg inside {[PAVG_MIN:PAVG_MAX]} && SETTINGS.swr_avg <= SAVG_MAX
        && SETTINGS.hold_qsec inside {[HOLD_MIN:HOLD_MAX]})
        else $error("setting out of range");
endmodule
bind msm_menu msm_menu_props u_msm_menu_props (.CLK, .RST, .PEAK_MODE, .AVG_MODE,
    .SWR_ALARM_RAW, .BELOW_FLOOR, .SETTINGS, .SETUP_ACTIVE, .CAL_ACTIVE, .SCREEN,
    .CPU_RESET, .SCALE_MAX_W, .SCALE_FULL_W, .SPAN_DB, .POWER_AVG_USED, .SWR_ALARM,
    .CLEAR_HELD_SWR);
`default_nettype wire

// *** verification/testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import msm_pkg::*;
    logic             CLK = 1'b0, RST = 1'b1, RESTORE_VALID = 1'b0, PEAK_MODE = 1'b0;
    logic             AVG_MODE = 1'b0, TRANSMITTING = 1'b0, SWR_ALARM_RAW = 1'b0;
    logic             BELOW_FLOOR = 1'b0, saw_cal = 1'b0, mode_key, dn_key, up_key;
    logic             SETUP_ACTIVE, CAL_ACTIVE, CPU_RESET, SWR_ALARM, CLEAR_HELD_SWR;
    logic [2:0]       want = 3'h0;
    logic [15:0]      SCALE_MAX_W, SCALE_FULL_W;
    logic [4:0]       SPAN_DB, POWER_AVG_USED;
    msm_settings_type RESTORE_DATA, SETTINGS;
    msm_screen_type   SCREEN;
    int               fails = 0, check_count = 0, cpu_pulses = 0, clears = 0, idx = 0, n;
    msm_keys u_msm_keys (.clk(CLK), .want, .mode_key, .dn_key, .up_key);
    msm_menu #(.ENTER_CYC(40), .EXIT_CYC(80), .STABLE_CYC(4)) u_msm_menu (.CLK, .RST,
        .MODE_KEY(mode_key), .DECREMENT_KEY(dn_key), .INCREMENT_KEY(up_key), .RESTORE_VALID,
        .RESTORE_DATA, .PEAK_MODE, .AVG_MODE, .TRANSMITTING, .SWR_ALARM_RAW, .BELOW_FLOOR,
        .SETTINGS, .SETUP_ACTIVE, .CAL_ACTIVE, .SCREEN, .CPU_RESET, .SCALE_MAX_W,
        .SCALE_FULL_W, .SPAN_DB, .POWER_AVG_USED, .SWR_ALARM, .CLEAR_HELD_SWR);
    initial forever #12.5 CLK = ~CLK;
    always @(posedge CLK) begin
        SWR_ALARM_RAW <= 1'($urandom);
        BELOW_FLOOR   <= 1'($urandom);
        TRANSMITTING  <= 1'($urandom);
        if (CPU_RESET === 1'b1) cpu_pulses++;
        if (CLEAR_HELD_SWR === 1'b1) clears++;
    end
    function automatic msm_settings_type defaults();
        return '{ALARM_DEF, FLOOR_DEF, PWR_NET_DEF, 2'h0, LOW_DEF, MID_DEF, HIGH_DEF,
                 SPAN_DEF_DB, PAVG_DEF, SAVG_DEF, HOLD_DEF, DECAY_DEF, COUPLER_DEF,
                 IDLE_DEF, 1'b0};
    endfunction
    function automatic int clampi(input int v, input int lo, input int hi);
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tap(input logic [2:0] k, input int cnt);
        repeat (cnt) begin
            want <= k;
            repeat (14) @(posedge CLK);
            want <= 3'h0;
            repeat (14) @(posedge CLK);
        end
    endtask
    task automatic hold_mode(input logic target);
        int i;
        want <= 3'h1;
        for (i = 0; i < 400 && SETUP_ACTIVE !== target; i++) begin
            @(posedge CLK);
            if (CAL_ACTIVE === 1'b1) saw_cal = 1'b1;
        end
        if (i == 400) fails++;
        if (i == 400) wrap_up();
        want <= 3'h0;
        repeat (14) @(posedge CLK);
    endtask
    task automatic next_screen();
        tap(3'h1, 1);
        idx = (idx + 1) % 10;
        check(SCREEN, 10'h1 << idx);
    endtask
    initial begin
        void'($urandom(24472));
        RESTORE_DATA = defaults();
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        repeat (3) @(posedge CLK);
        check(SETTINGS, defaults());
        tap(3'h2, 1);
        check(SETTINGS, defaults());
        hold_mode(1'b1);
        check(SCREEN, SCR_REF);
        tap(3'h4, 1);
        check(SETTINGS.temp_celsius, 1);
        tap(3'h2, 1);
        check(cpu_pulses, 1);
        next_screen();
        n = 5 + $urandom % 30;
        tap(3'h2, 12);
        check(SETTINGS.alarm_tenths, ALARM_MIN);
        tap(3'h4, n);
        check(SETTINGS.alarm_tenths, clampi(ALARM_MIN + n, ALARM_MIN, ALARM_MAX));
        next_screen();
        n = 1 + $urandom % 8;
        tap(3'h2, n);
        tap(3'h4, 1);
        check(SETTINGS.alarm_power_floor, n % 4);
        check(SETTINGS.power_net, 0);
        next_screen();
        tap(3'h2, 1);
        check(SETTINGS.range_sel, 1);
        next_screen();
        tap(3'h4, 3);
        check(SCALE_MAX_W, 175);
        check(SCALE_FULL_W, 192);
        next_screen();
        tap(3'h2, 2);
        check(SPAN_DB, SPAN_DEF_DB - 2);
        PEAK_MODE <= 1'b1;
        repeat (3) @(posedge CLK);
        check(SPAN_DB, PEAK_SPAN_DB);
        next_screen();
        tap(3'h2, 17);
        tap(3'h4, 4);
        AVG_MODE <= 1'b1;
        repeat (3) @(posedge CLK);
        check(POWER_AVG_USED, PAVG_MIN);
        check(SETTINGS.swr_avg, 0);
        next_screen();
        tap(3'h4, 15);
        check(SETTINGS.hold_qsec, HOLD_MAX);
        next_screen();
        tap(3'h2, 3);
        check(SETTINGS.decay, 0);
        next_screen();
        tap(3'h4, 4);
        check(SETTINGS.coupler, 4);
        check(SCALE_MAX_W, 175 * 333 / 100);
        check(clears, 0);
        tap(3'h6, 3);
        repeat (40) @(posedge CLK);
        check(SETTINGS.idle_style, IDLE_HOLD);
        check(SETTINGS.coupler, 4);
        check(clears != 0, 1);
        next_screen();
        hold_mode(1'b0);
        check(saw_cal, 1);
        RESTORE_DATA.alarm_tenths <= 6'h21;
        RESTORE_VALID <= 1'b1;
        repeat (3) @(posedge CLK);
        check(SETTINGS.alarm_tenths, 6'h21);
        wrap_up();
    end
endmodule
`default_nettype wire
